/* src/tsio_pkg.sv */
// shared constants and types of the touch sensor i/o port
package tsio_pkg;
  // ---------------------------------------------------------------
  // port shape
  // ---------------------------------------------------------------
  localparam int NLINES = 7;
  localparam int NKEYS  = 6;

  // ---------------------------------------------------------------
  // serial bus: slave address value is arbitrary
  // ---------------------------------------------------------------
  localparam logic [6:0] SLAVE_ADDR = 7'h12;

  // ---------------------------------------------------------------
  // register offsets (byte pointer of the serial bus)
  // ---------------------------------------------------------------
  localparam logic [7:0] OFF_DET_STAT  = 8'h04;
  localparam logic [7:0] OFF_IN_STAT   = 8'h05;
  localparam logic [7:0] OFF_DIR       = 8'h17;
  localparam logic [7:0] OFF_PWM_SEL   = 8'h18;
  localparam logic [7:0] OFF_DET_SEL   = 8'h19;
  localparam logic [7:0] OFF_POL       = 8'h1A;
  localparam logic [7:0] OFF_USER_OUT  = 8'h1B;
  localparam logic [7:0] OFF_PWM_LEVEL = 8'h1C;

  // ---------------------------------------------------------------
  // values after reset
  // ---------------------------------------------------------------
  localparam logic [6:0] RST_DIR        = 7'h00;
  localparam logic [6:0] RST_DIR_ALONE  = 7'h7F;
  localparam logic [6:0] RST_PWM_SEL    = 7'h00;
  localparam logic [6:0] RST_DET_SEL    = 7'h7F;
  localparam logic [6:0] RST_POL        = 7'h7F;
  localparam logic [6:0] RST_USER_OUT   = 7'h00;
  localparam logic [7:0] RST_PWM_LEVEL  = 8'h00;
  // cycles after reset release before the strap is sampled
  localparam logic [1:0] STRAP_DELAY    = 2'h3;
  // bits in a serial byte
  localparam logic [3:0] BYTE_BITS      = 4'h8;

  // ---------------------------------------------------------------
  // serial slave states, gray along the usual path
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    TSIO_IDLE     = 3'b000,
    TSIO_ADDR     = 3'b001,
    TSIO_ADDR_ACK = 3'b011,
    TSIO_WR_BYTE  = 3'b010,
    TSIO_WR_ACK   = 3'b110,
    TSIO_RD_BYTE  = 3'b111,
    TSIO_RD_ACK   = 3'b101
  } tsio_state_t;
endpackage

/* src/tsio_line_if.sv */
// per-line configuration and pin drive between port core and line driver
`timescale 1ns/1ps
interface tsio_line_if;
  logic ce;
  logic dir;
  logic pwm_sel;
  logic det_sel;
  logic pol;
  logic user_bit;
  logic det_bit;
  logic pwm_on;
  logic pin_out;
  logic pin_oe;

  modport ctrl (output ce, dir, pwm_sel, det_sel, pol, user_bit, det_bit, pwm_on,
                input pin_out, pin_oe);
  modport line (input ce, dir, pwm_sel, det_sel, pol, user_bit, det_bit, pwm_on,
                output pin_out, pin_oe);
endinterface // tsio_line_if

/* src/tsio_line.sv */
// one port line output driver: source select, pwm gate, polarity
`timescale 1ns/1ps
module tsio_line (
  // clock and reset
  input wire logic  i_clk,
  input wire logic  i_rst,
  // line configuration and pin
  tsio_line_if.line lif
);
  logic act;

  // ---------------------------------------------------------------
  // asserted level before polarity
  // ---------------------------------------------------------------
  // pwm gates only the user buffer path, detection drives plainly
  always_comb begin
    if (lif.det_sel) begin
      act = lif.det_bit; // [R10]
    end else begin
      act = lif.user_bit & (~lif.pwm_sel | lif.pwm_on); // [R8] [R11]
    end
  end

  // registered pin drive; an input line never drives
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      lif.pin_out <= 1'b0;
      lif.pin_oe  <= 1'b0;
    end else if (lif.ce) begin
      lif.pin_oe  <= lif.dir; // [R1] [R5]
      lif.pin_out <= lif.pol ? act : ~act; // [R12]
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_input_released: assert property ( // [R5]
    @(posedge i_clk) disable iff (i_rst)
    (lif.ce && !lif.dir) |=> !lif.pin_oe)
    else $error("input line drives pin");
  a_detect_follow: assert property ( // [R10]
    @(posedge i_clk) disable iff (i_rst)
    (lif.ce && lif.det_sel) |=> lif.pin_out == ($past(lif.pol) ~^ $past(lif.det_bit)))
    else $error("line does not follow detection");
  a_user_follow: assert property ( // [R11]
    @(posedge i_clk) disable iff (i_rst)
    (lif.ce && !lif.det_sel && !lif.pwm_sel) |=> lif.pin_out == ($past(lif.pol) ~^ $past(lif.user_bit)))
    else $error("line does not follow user buffer");
  a_pwm_gate_off: assert property ( // [R8]
    @(posedge i_clk) disable iff (i_rst)
    (lif.ce && !lif.det_sel && lif.pwm_sel && !lif.pwm_on) |=> lif.pin_out == !$past(lif.pol))
    else $error("pwm line asserted outside duty");
endmodule // tsio_line

/* src/tsio_port.sv */
// touch sensor i/o port: serial register slave, change line, seven lines
`timescale 1ns/1ps
// Contract
// [R1] seven lines, each input or output
// [R2] one shared 256-step pwm level
// [R3] normal start-up: every line an input
// [R4] strap low data, high clock: all outputs
// [R5] direction one output; input ignores other masks
// [R6] input levels shown in input status
// [R7] input level change asserts change line
// [R8] pwm mask gives pwm on user outputs
// [R9] host writes pwm level; all pwm lines use
// [R10] detect mask ties output to key detection
// [R11] detect mask zero follows user buffer
// [R12] polarity one active high, zero low
// [R13] change line active low, released by status read
// [R14] reverted status: any read releases line
// [R15] pwm duty proportional to level, zero never
module tsio_port (
  // clock, reset, enable
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic       i_ce,
  // serial bus pins, open drain data
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  output logic            o_sda,
  output logic            o_sda_oe,
  // change line, open drain
  output logic            o_change_notify_n,
  output logic            o_change_notify_n_oe,
  // key detection from the sensing core
  input  wire logic [5:0] i_key_detect,
  // port lines
  input  wire logic [6:0] i_port_line,
  output logic      [6:0] o_port_line,
  output logic      [6:0] o_port_line_oe,
  // strap result
  output logic            o_standalone
);
  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic                scl_m_r, scl_s_r, scl_d_r;
  logic                sda_m_r, sda_s_r, sda_d_r;
  logic [6:0]          port_m_r, port_s_r;
  logic                scl_rise, scl_fall, bus_start, bus_stop;
  logic [1:0]          strap_cnt_r;
  logic                strap_take, standalone_r;
  logic [6:0]          dir_r, pwm_sel_r, det_sel_r, pol_r, user_r;
  logic [7:0]          pwm_level_r, pwm_cnt_r;
  logic                pwm_on;
  tsio_pkg::tsio_state_t st_r;
  logic [3:0]          cnt_r;
  logic [7:0]          sh_r, ptr_r, rd_data;
  logic                first_r, rw_r, nack_r, sda_oe_r;
  logic                wr_en_r, rd_evt_r;
  logic [7:0]          wr_addr_r, wr_data_r, rd_addr_r;
  logic [6:0]          in_status, det_ext;
  logic [12:0]         stat_now, stat_prev_r, snap_r;
  logic                chg_evt, chg_r, stat_read;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  // idle bus reads high so reset cannot fake a start condition
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      {scl_m_r, scl_s_r, scl_d_r} <= 3'h7;
      {sda_m_r, sda_s_r, sda_d_r} <= 3'h7;
      port_m_r <= 7'h00;
      port_s_r <= 7'h00;
    end else if (i_ce) begin
      {scl_m_r, scl_s_r, scl_d_r} <= {i_scl, scl_m_r, scl_s_r};
      {sda_m_r, sda_s_r, sda_d_r} <= {i_sda, sda_m_r, sda_s_r};
      port_m_r <= i_port_line;
      port_s_r <= port_m_r;
    end
  end

  // bus edges and conditions from the settled copies only
  assign scl_rise  = scl_s_r & ~scl_d_r;
  assign scl_fall  = ~scl_s_r & scl_d_r;
  assign bus_start = scl_s_r & scl_d_r & sda_d_r & ~sda_s_r;
  assign bus_stop  = scl_s_r & scl_d_r & ~sda_d_r & sda_s_r;

  // ---------------------------------------------------------------
  // standalone strap
  // ---------------------------------------------------------------
  // sampled once, after the synchronisers hold true pin levels
  assign strap_take = i_ce && (strap_cnt_r == tsio_pkg::STRAP_DELAY - 2'h1);
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      strap_cnt_r  <= 2'h0;
      standalone_r <= 1'b0;
    end else if (i_ce) begin
      if (strap_cnt_r != tsio_pkg::STRAP_DELAY) begin
        strap_cnt_r <= strap_cnt_r + 2'h1;
      end
      if (strap_take) begin
        standalone_r <= ~sda_s_r & scl_s_r; // [R4]
      end
    end
  end
  assign o_standalone = standalone_r;

  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      dir_r       <= tsio_pkg::RST_DIR; // [R3]
      pwm_sel_r   <= tsio_pkg::RST_PWM_SEL;
      det_sel_r   <= tsio_pkg::RST_DET_SEL;
      pol_r       <= tsio_pkg::RST_POL;
      user_r      <= tsio_pkg::RST_USER_OUT;
      pwm_level_r <= tsio_pkg::RST_PWM_LEVEL;
    end else if (i_ce) begin
      if (strap_take && ~sda_s_r && scl_s_r) begin
        dir_r <= tsio_pkg::RST_DIR_ALONE; // [R4]
      end else if (wr_en_r) begin
        case (wr_addr_r)
          tsio_pkg::OFF_DIR:       dir_r       <= wr_data_r[6:0]; // [R1]
          tsio_pkg::OFF_PWM_SEL:   pwm_sel_r   <= wr_data_r[6:0];
          tsio_pkg::OFF_DET_SEL:   det_sel_r   <= wr_data_r[6:0];
          tsio_pkg::OFF_POL:       pol_r       <= wr_data_r[6:0];
          tsio_pkg::OFF_USER_OUT:  user_r      <= wr_data_r[6:0];
          tsio_pkg::OFF_PWM_LEVEL: pwm_level_r <= wr_data_r; // [R9]
          default: ; // unmapped and status offsets ignore writes
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------
  assign in_status = port_s_r & ~dir_r; // [R6]
  assign det_ext   = {1'b0, i_key_detect};
  always_comb begin
    rd_data = 8'h00;
    case (ptr_r)
      tsio_pkg::OFF_DET_STAT:  rd_data = {1'b0, det_ext};
      tsio_pkg::OFF_IN_STAT:   rd_data = {1'b0, in_status}; // [R6]
      tsio_pkg::OFF_DIR:       rd_data = {1'b0, dir_r};
      tsio_pkg::OFF_PWM_SEL:   rd_data = {1'b0, pwm_sel_r};
      tsio_pkg::OFF_DET_SEL:   rd_data = {1'b0, det_sel_r};
      tsio_pkg::OFF_POL:       rd_data = {1'b0, pol_r};
      tsio_pkg::OFF_USER_OUT:  rd_data = {1'b0, user_r};
      tsio_pkg::OFF_PWM_LEVEL: rd_data = pwm_level_r;
      default:                 rd_data = 8'h00;
    endcase
  end

  // ---------------------------------------------------------------
  // serial slave
  // ---------------------------------------------------------------
  // pointer byte first, then data with auto increment; a read
  // prefetches the next byte at each acknowledge
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_r <= tsio_pkg::TSIO_IDLE;
      {cnt_r, sh_r, ptr_r} <= 20'h00000;
      {first_r, rw_r, nack_r, sda_oe_r, wr_en_r, rd_evt_r} <= 6'h00;
      {wr_addr_r, wr_data_r, rd_addr_r} <= 24'h000000;
    end else if (i_ce) begin
      wr_en_r  <= 1'b0;
      rd_evt_r <= 1'b0;
      if (standalone_r || bus_stop) begin
        st_r     <= tsio_pkg::TSIO_IDLE;
        sda_oe_r <= 1'b0;
      end else if (bus_start) begin
        st_r     <= tsio_pkg::TSIO_ADDR;
        cnt_r    <= 4'h0;
        sda_oe_r <= 1'b0;
      end else if (scl_rise) begin
        if (st_r == tsio_pkg::TSIO_ADDR || st_r == tsio_pkg::TSIO_WR_BYTE) begin
          sh_r  <= {sh_r[6:0], sda_s_r};
          cnt_r <= cnt_r + 4'h1;
        end
        if (st_r == tsio_pkg::TSIO_RD_ACK) begin
          nack_r <= sda_s_r;
        end
      end else if (scl_fall) begin
        case (st_r)
          tsio_pkg::TSIO_ADDR: begin
            if (cnt_r == tsio_pkg::BYTE_BITS) begin
              if (sh_r[7:1] == tsio_pkg::SLAVE_ADDR) begin
                st_r     <= tsio_pkg::TSIO_ADDR_ACK;
                sda_oe_r <= 1'b1;
                rw_r     <= sh_r[0];
              end else begin
                st_r <= tsio_pkg::TSIO_IDLE;
              end
            end
          end
          tsio_pkg::TSIO_ADDR_ACK: begin
            if (rw_r) begin
              st_r      <= tsio_pkg::TSIO_RD_BYTE;
              sh_r      <= rd_data;
              sda_oe_r  <= ~rd_data[7];
              cnt_r     <= 4'h0;
              rd_evt_r  <= 1'b1;
              rd_addr_r <= ptr_r;
              ptr_r     <= ptr_r + 8'h01;
            end else begin
              st_r     <= tsio_pkg::TSIO_WR_BYTE;
              sda_oe_r <= 1'b0;
              cnt_r    <= 4'h0;
              first_r  <= 1'b1;
            end
          end
          tsio_pkg::TSIO_WR_BYTE: begin
            if (cnt_r == tsio_pkg::BYTE_BITS) begin
              st_r     <= tsio_pkg::TSIO_WR_ACK;
              sda_oe_r <= 1'b1;
              cnt_r    <= 4'h0;
              first_r  <= 1'b0;
              if (first_r) begin
                ptr_r <= sh_r;
              end else begin
                wr_en_r   <= 1'b1; // [R9]
                wr_addr_r <= ptr_r;
                wr_data_r <= sh_r;
                ptr_r     <= ptr_r + 8'h01;
              end
            end
          end
          tsio_pkg::TSIO_WR_ACK: begin
            st_r     <= tsio_pkg::TSIO_WR_BYTE;
            sda_oe_r <= 1'b0;
          end
          tsio_pkg::TSIO_RD_BYTE: begin
            if (cnt_r == tsio_pkg::BYTE_BITS - 4'h1) begin
              st_r     <= tsio_pkg::TSIO_RD_ACK;
              sda_oe_r <= 1'b0;
            end else begin
              sh_r     <= {sh_r[6:0], 1'b0};
              sda_oe_r <= ~sh_r[6];
              cnt_r    <= cnt_r + 4'h1;
            end
          end
          tsio_pkg::TSIO_RD_ACK: begin
            if (nack_r) begin
              st_r <= tsio_pkg::TSIO_IDLE;
            end else begin
              st_r      <= tsio_pkg::TSIO_RD_BYTE;
              sh_r      <= rd_data;
              sda_oe_r  <= ~rd_data[7];
              cnt_r     <= 4'h0;
              rd_evt_r  <= 1'b1;
              rd_addr_r <= ptr_r;
              ptr_r     <= ptr_r + 8'h01;
            end
          end
          default: st_r <= tsio_pkg::TSIO_IDLE;
        endcase
      end
    end
  end
  assign o_sda    = 1'b0;
  assign o_sda_oe = sda_oe_r;

  // ---------------------------------------------------------------
  // change line
  // ---------------------------------------------------------------
  // a touch then release before the read still leaves the line low
  assign stat_now  = {det_ext[5:0], in_status};
  // no events until the synchronisers hold true pin levels after reset
  assign chg_evt   = (stat_now != stat_prev_r) && (strap_cnt_r == tsio_pkg::STRAP_DELAY); // [R7]
  assign stat_read = rd_evt_r && (rd_addr_r == tsio_pkg::OFF_IN_STAT ||
                                  rd_addr_r == tsio_pkg::OFF_DET_STAT);
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      stat_prev_r <= 13'h0000;
      snap_r      <= 13'h0000;
      chg_r       <= 1'b0;
    end else if (i_ce) begin
      stat_prev_r <= stat_now;
      if (stat_read) begin
        snap_r <= stat_now;
      end
      // a new event wins over a clearing read in the same cycle
      if (chg_evt) begin
        chg_r <= 1'b1; // [R7]
      end else if (stat_read) begin
        chg_r <= 1'b0; // [R13]
      end else if (rd_evt_r && stat_now == snap_r) begin
        chg_r <= 1'b0; // [R14]
      end
    end
  end
  assign o_change_notify_n    = 1'b0; // [R13]
  assign o_change_notify_n_oe = chg_r;

  // ---------------------------------------------------------------
  // pwm generator
  // ---------------------------------------------------------------
  // 256-cycle period; level 255 still leaves one cycle off
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pwm_cnt_r <= 8'h00;
    end else if (i_ce) begin
      pwm_cnt_r <= pwm_cnt_r + 8'h01;
    end
  end
  assign pwm_on = pwm_cnt_r < pwm_level_r; // [R2] [R15]

  // ---------------------------------------------------------------
  // line drivers
  // ---------------------------------------------------------------
  for (genvar g = 0; g < tsio_pkg::NLINES; g++) begin : g_line
    tsio_line_if lif ();
    assign lif.ce       = i_ce;
    assign lif.dir      = dir_r[g];
    assign lif.pwm_sel  = pwm_sel_r[g];
    assign lif.det_sel  = det_sel_r[g];
    assign lif.pol      = pol_r[g];
    assign lif.user_bit = user_r[g];
    assign lif.det_bit  = det_ext[g];
    assign lif.pwm_on   = pwm_on;
    tsio_line u_line (
      .i_clk (i_clk),
      .i_rst (i_rst),
      .lif   (lif.line)
    );
    assign o_port_line[g]    = lif.pin_out;
    assign o_port_line_oe[g] = lif.pin_oe;
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_dir_after_reset: assert property ( // [R3]
    @(posedge i_clk) disable iff (i_rst)
    $fell(i_rst) |-> dir_r == tsio_pkg::RST_DIR)
    else $error("lines not inputs after reset");
  a_standalone_dir: assert property ( // [R4]
    @(posedge i_clk) disable iff (i_rst)
    $rose(standalone_r) |-> dir_r == tsio_pkg::RST_DIR_ALONE)
    else $error("standalone lines not outputs");
  a_status_masked: assert property ( // [R6]
    @(posedge i_clk) disable iff (i_rst)
    (ptr_r == tsio_pkg::OFF_IN_STAT) |-> (rd_data[6:0] & dir_r) == 7'h00)
    else $error("output line shown in input status");
  a_change_sets: assert property ( // [R7]
    @(posedge i_clk) disable iff (i_rst)
    (i_ce && chg_evt) |=> o_change_notify_n_oe)
    else $error("change line not asserted");
  a_change_holds: assert property ( // [R14]
    @(posedge i_clk) disable iff (i_rst)
    (chg_r && !rd_evt_r) |=> chg_r)
    else $error("change line released without read");
  a_status_clears: assert property ( // [R13]
    @(posedge i_clk) disable iff (i_rst)
    (i_ce && stat_read && !chg_evt) |=> !o_change_notify_n_oe)
    else $error("status read kept change line");
  a_pwm_zero_off: assert property ( // [R15]
    @(posedge i_clk) disable iff (i_rst)
    (pwm_level_r == 8'h00) |-> !pwm_on)
    else $error("pwm on at level zero");
  a_pwm_level_write: assert property ( // [R9]
    @(posedge i_clk) disable iff (i_rst)
    (i_ce && wr_en_r && wr_addr_r == tsio_pkg::OFF_PWM_LEVEL) |=> pwm_level_r == $past(wr_data_r))
    else $error("pwm level write lost");
endmodule // tsio_port

/* dv/tsio_host_model.sv */
// host model that configures the i/o port over the serial bus
`timescale 1ns/1ps
module tsio_host_model (
  // clock
  input  wire logic i_clk,
  // bus wires: clock pushed, data only pulled low
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda_pull
);
  // half phase in cycles; the slave needs at least 2
  localparam int H = 8;
  // bus idles released, clock stands high between frames
  initial begin
    o_scl      = 1'b1;
    o_sda_pull = 1'b0;
  end
  // each change waits a half phase and lands on a falling edge
  task automatic step(input logic scl, input logic pull);
    repeat (H) @(negedge i_clk);
    o_scl      = scl;
    o_sda_pull = pull;
  endtask
  // data moves only while the clock is low, so no false start or stop
  task automatic bit_cycle(input logic pull, output logic seen);
    step(1'b0, o_sda_pull);
    step(1'b0, pull);
    step(1'b1, pull);
    repeat (H) @(negedge i_clk);
    seen = i_sda;
  endtask
  task automatic start_cond();
    step(1'b0, o_sda_pull);
    step(1'b0, 1'b0);
    step(1'b1, 1'b0);
    step(1'b1, 1'b1);
  endtask
  task automatic stop_cond();
    step(1'b0, o_sda_pull);
    step(1'b0, 1'b1);
    step(1'b1, 1'b1);
    step(1'b1, 1'b0);
  endtask
  // msb first, then the ninth bit carries the slave's ack
  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int k = 7; k >= 0; k--) bit_cycle(~b[k], s);
    bit_cycle(1'b0, s);
    ack = ~s;
  endtask
  // a read byte ends with our ack, or a nack on the last one
  task automatic get_byte(input logic last, output logic [7:0] b);
    logic s;
    for (int k = 7; k >= 0; k--) begin
      bit_cycle(1'b0, s);
      b[k] = s;
    end
    bit_cycle(~last, s);
  endtask
endmodule // tsio_host_model

/* dv/tsio_tb.sv */
// self-checking bench of the touch sensor i/o port
`timescale 1ns/1ps
module tb;
  // ---------------------------------------------------------------
  // clock, wires and design
  // ---------------------------------------------------------------
  logic       clk   = 1'b0;
  logic       rst   = 1'b1;
  logic       strap = 1'b0;
  logic [5:0] key   = 6'h00;
  logic [6:0] ext   = 7'h00;
  logic       scl, pull, sda_oe, sda_o, chg_oe, chg_o, chg_w, alone, sda_w;
  logic [6:0] line_o, line_oe, pins;
  int         errors    = 0;
  int         tests_run = 0;
  int         cycles    = 0;
  localparam logic [7:0] AW = {tsio_pkg::SLAVE_ADDR, 1'b0};
  always #5 clk = ~clk;
  // pulled-up data wire; the strap holds it low through power-up
  assign sda_w = (sda_oe ? sda_o : 1'b1) & ~pull & ~strap;
  // pulled-up change line, low while asserted
  assign chg_w = chg_oe ? chg_o : 1'b1;
  // driven lines show the design's level, the others the outside one
  assign pins  = (line_oe & line_o) | (~line_oe & ext);
  tsio_port dut (
    .i_clk                (clk),
    .i_rst                (rst),
    .i_ce                 (1'b1),
    .i_scl                (scl),
    .i_sda                (sda_w),
    .o_sda                (sda_o),
    .o_sda_oe             (sda_oe),
    .o_change_notify_n    (chg_o),
    .o_change_notify_n_oe (chg_oe),
    .i_key_detect         (key),
    .i_port_line          (pins),
    .o_port_line          (line_o),
    .o_port_line_oe       (line_oe),
    .o_standalone         (alone)
  );
  tsio_host_model host (.i_clk(clk), .i_sda(sda_w), .o_scl(scl), .o_sda_pull(pull));
  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] seen);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic reg_write(input logic [7:0] ptr, input logic [7:0] d);
    logic [2:0] a;
    host.start_cond();
    host.put_byte(AW, a[2]);
    host.put_byte(ptr, a[1]);
    host.put_byte(d, a[0]);
    host.stop_cond();
    check("write acks", 16'h7, a);
  endtask
  // pointer write, repeated start, one byte read with a closing nack
  task automatic reg_read(input logic [7:0] ptr, output logic [7:0] d);
    logic [2:0] a;
    host.start_cond();
    host.put_byte(AW, a[2]);
    host.put_byte(ptr, a[1]);
    host.start_cond();
    host.put_byte(AW | 8'h01, a[0]);
    host.get_byte(1'b1, d);
    host.stop_cond();
    check("read acks", 16'h7, a);
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic test_defaults();
    logic [7:0] offs [7];
    logic [7:0] exps [7];
    logic [7:0] d;
    offs = '{tsio_pkg::OFF_DIR, tsio_pkg::OFF_PWM_SEL, tsio_pkg::OFF_DET_SEL, tsio_pkg::OFF_POL,
             tsio_pkg::OFF_USER_OUT, tsio_pkg::OFF_PWM_LEVEL, 8'h30};
    exps = '{8'h00, tsio_pkg::RST_PWM_SEL, tsio_pkg::RST_DET_SEL, tsio_pkg::RST_POL,
             tsio_pkg::RST_USER_OUT, tsio_pkg::RST_PWM_LEVEL, 8'h00};
    check("line enables after reset", 16'h0, line_oe);
    check("strap flag", 16'h0, alone);
    for (int k = 0; k < 7; k++) begin
      reg_read(offs[k], d);
      check("register reset value", exps[k], d);
    end
  endtask
  task automatic test_inputs();
    logic [7:0] d;
    reg_read(tsio_pkg::OFF_IN_STAT, d);
    check("change line idle", 16'h1, chg_w);
    ext = 7'h55;
    wt(8);
    check("change line on input edge", 16'h0, chg_w);
    reg_read(tsio_pkg::OFF_IN_STAT, d);
    check("input status", 16'h55, d);
    check("change line after status read", 16'h1, chg_w);
    ext = 7'h54;
    wt(8);
    ext = 7'h55;
    wt(8);
    check("change line after reverted input", 16'h0, chg_w);
    reg_read(tsio_pkg::OFF_DIR, d);
    check("change line after other read", 16'h1, chg_w);
  endtask
  task automatic test_outputs();
    logic [7:0] d;
    ext = 7'h7F;
    reg_write(tsio_pkg::OFF_DIR, 8'h0F);
    check("line enables", 16'h0F, line_oe);
    reg_read(tsio_pkg::OFF_IN_STAT, d);
    check("input status of mixed port", 16'h70, d);
    reg_write(tsio_pkg::OFF_DIR, 8'h7F);
    key = 6'h2A;
    wt(4);
    check("lines follow detection", 16'h2A, line_o);
    check("change line on key change", 16'h0, chg_w);
    reg_read(tsio_pkg::OFF_DET_STAT, d);
    check("detection status", 16'h2A, d);
    check("change line after detection read", 16'h1, chg_w);
    reg_write(tsio_pkg::OFF_POL, 8'h00);
    check("active low lines", 16'h55, line_o);
    reg_write(tsio_pkg::OFF_DET_SEL, 8'h00);
    reg_write(tsio_pkg::OFF_USER_OUT, 8'h33);
    check("active low user lines", 16'h4C, line_o);
  endtask
  // line 0 in pwm, line 1 plain digital; both asserted by the user buffer
  task automatic test_pwm();
    logic [7:0] lv [3];
    logic [7:0] d;
    int         hi, lo;
    lv = '{8'h00, 8'h40, 8'hFF};
    reg_write(tsio_pkg::OFF_POL, 8'h7F);
    reg_write(tsio_pkg::OFF_USER_OUT, 8'h03);
    reg_write(tsio_pkg::OFF_PWM_SEL, 8'h01);
    for (int k = 0; k < 3; k++) begin
      reg_write(tsio_pkg::OFF_PWM_LEVEL, lv[k]);
      reg_read(tsio_pkg::OFF_PWM_LEVEL, d);
      check("pwm level", lv[k], d);
      hi = 0;
      lo = 0;
      repeat (256) begin
        @(negedge clk);
        hi += (line_o[0] === 1'b1);
        lo += (line_o[1] !== 1'b1);
      end
      check("pwm high cycles per period", lv[k], 16'(hi));
      check("digital line low cycles", 16'h0, 16'(lo));
    end
  endtask
  task automatic test_standalone();
    strap = 1'b1;
    rst   = 1'b1;
    wt(12);
    rst   = 1'b0;
    wt(8);
    check("strap flag", 16'h1, alone);
    check("standalone line enables", 16'h7F, line_oe);
    key = 6'h15;
    wt(4);
    check("standalone lines show keys", 16'h15, line_o);
  endtask
  // ---------------------------------------------------------------
  // sequence and hang guard
  // ---------------------------------------------------------------
  initial begin
    wt(12);
    rst = 1'b0;
    wt(10);
    test_defaults();
    test_inputs();
    test_outputs();
    test_pwm();
    test_standalone();
    give_verdict();
  end
  // about twice the expected run; a hang counts as a mismatch
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      errors++;
      give_verdict();
    end
  end
endmodule // tb
